/* File: rtl/pmr_pkg.sv */
// package: register map, fields and types of the power mode and regulator control
package pmr_pkg;
  localparam logic [7:0] PMR_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] PMR_ADDR_WAKE_FLAGS = 8'hAD;
  localparam logic [7:0] PMR_ADDR_FIVE_VOLT_REG = 8'hC6;
  localparam logic [7:0] PMR_ADDR_CORE_REG = 8'hC9;
  localparam logic [7:0] PMR_ADDR_POWER_CONTROL_EXT = 8'hE4;
  localparam logic [7:0] PMR_RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] PMR_RST_WAKE_FLAGS = 8'h00;
  localparam logic [7:0] PMR_RST_FIVE_VOLT_REG = 8'h00;
  localparam logic [7:0] PMR_RST_CORE_REG = 8'h00;
  localparam logic [7:0] PMR_RST_POWER_CONTROL_EXT = 8'h00;
  localparam int PMR_BIT_IDLE = 0;
  localparam int PMR_BIT_STOP = 1;
  localparam int PMR_POS_FW_FLAGS = 2;
  localparam int PMR_NUM_FW_FLAGS = 6;
  localparam int PMR_BIT_SUSPEND = 6;
  localparam int PMR_BIT_SNOOZE = 7;
  localparam int PMR_NUM_WAKE = 6;
  localparam int PMR_BIT_SHUTDOWN_CFG = 3;
  localparam int PMR_BIT_LOW_BIAS = 1;
  localparam int PMR_BIT_BIAS_OFF = 2;
  localparam int PMR_BIT_REG_OFF = 7;
  // wake flags, msb first: logic unit is bit 5, comparator bit 0
  typedef struct packed {
    logic logic_unit;
    logic usb_resume;
    logic serial_slave;
    logic timer_four;
    logic pin_match;
    logic comparator_zero;
  } pmr_wake_t;
  typedef struct packed {
    logic off;
    logic bias_off;
    logic low_bias;
  } pmr_five_volt_t;
  typedef enum logic [5:0] {
    PMR_NORMAL = 6'h01,
    PMR_IDLE = 6'h02,
    PMR_STOP = 6'h04,
    PMR_SUSPEND = 6'h08,
    PMR_SNOOZE = 6'h10,
    PMR_SHUTDOWN = 6'h20
  } pmr_mode_t;
endpackage

/* File: rtl/pmr_power_ctrl.sv */
// power mode sequencer, wake flags and regulator control registers
`timescale 1ns/100ps
// Functional notes
// - in shutdown only the reset pin or power cycle reset and wake
// - shutdown keeps nothing; all registers return to reset values
// - leaving shutdown is reported as a power-on reset
// - debug cannot attach while in shutdown
// - shutdown halts core, core LDO off, pins hold their state
// - shutdown-on-stop 0: regulator stays on, any enabled reset exits stop
// - stop and idle request bits enter mode and read back 0
// - six firmware flags in power control, reset 0, no effect
// - suspend request halts fast oscillators and gates system clock
// - snooze request also puts core LDO in low-current standby
// - logic unit event sets its wake flag
// - usb resume event sets its wake flag
// - serial slave byte received sets its wake flag
// - timer four overflow sets its wake flag
// - pin match event sets its wake flag
// - comparator zero falling edge sets its wake flag
// - after reset the 5 V regulator is in normal mode
// - low-bias enable places 5 V regulator in suspend power mode
// - bias-off disables regulator bias regardless of low-bias enable
module pmr_power_ctrl
  import pmr_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // reset and wake sources, fast oscillator A select
  input wire logic external_reset_pin_n_in,
  input wire logic power_on_reset_in,
  input wire logic internal_reset_in,
  input wire logic irq_pending_in,
  input wire logic fast_internal_osc_a_sel_in,
  // wake events as one-cycle pulses, comparator level (falling edge wakes), debug attach request
  input wire logic logic_unit_event_in,
  input wire logic usb_resume_event_in,
  input wire logic serial_slave_byte_in,
  input wire logic timer_four_ovf_in,
  input wire logic pin_match_event_in,
  input wire logic comparator_zero_in,
  input wire logic debug_attach_req_in,
  // special-function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  // power control outputs
  output logic core_halt_out,
  output logic sysclk_gate_out,
  output logic fast_osc_halt_out,
  output logic core_ldo_off_out,
  output logic core_ldo_standby_out,
  output logic pin_hold_out,
  output logic debug_attach_ok_out,
  output logic device_reset_out,
  output logic por_reported_out,
  output logic five_volt_low_bias_out,
  output logic five_volt_bias_off_out,
  output logic five_volt_off_out,
  output pmr_mode_t mode_out
);
  pmr_mode_t mode;
  logic [PMR_NUM_FW_FLAGS-1:0] fw_flags;
  pmr_wake_t wake;
  pmr_five_volt_t five_volt;
  logic shutdown_cfg;
  logic cmp_prev;
  logic por_flag;
  logic [PMR_NUM_WAKE-1:0] wake_evt;
  logic any_wake;
  logic shutdown_exit;
  logic stop_exit;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  assign wake_evt = {logic_unit_event_in, usb_resume_event_in, serial_slave_byte_in,
                     timer_four_ovf_in, pin_match_event_in,
                     cmp_prev & ~comparator_zero_in};
  assign any_wake = |wake_evt;
  // only the pin or a power cycle counts in shutdown
  assign shutdown_exit = ~external_reset_pin_n_in | power_on_reset_in;
  assign stop_exit = shutdown_exit | internal_reset_in;

  // power mode sequencer
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mode <= PMR_NORMAL;
    end else begin
      unique case (mode)
        PMR_NORMAL: begin
          if (sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL) && sfr_wdata_in[PMR_BIT_STOP]) begin
            mode <= shutdown_cfg ? PMR_SHUTDOWN : PMR_STOP;
          end else if (sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL) && sfr_wdata_in[PMR_BIT_IDLE]) begin
            mode <= PMR_IDLE;
          end else if (sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL_EXT)
                       && sfr_wdata_in[PMR_BIT_SNOOZE] && fast_internal_osc_a_sel_in) begin
            mode <= PMR_SNOOZE;
          end else if (sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL_EXT)
                       && sfr_wdata_in[PMR_BIT_SUSPEND] && fast_internal_osc_a_sel_in) begin
            mode <= PMR_SUSPEND;
          end
        end
        PMR_IDLE: begin
          if (irq_pending_in || stop_exit) begin
            mode <= PMR_NORMAL;
          end
        end
        PMR_STOP: begin
          if (stop_exit) begin
            mode <= PMR_NORMAL;
          end
        end
        PMR_SUSPEND, PMR_SNOOZE: begin
          if (any_wake || stop_exit) begin
            mode <= PMR_NORMAL;
          end
        end
        PMR_SHUTDOWN: begin
          if (shutdown_exit) begin
            mode <= PMR_NORMAL;
          end
        end
        default: mode <= PMR_NORMAL;
      endcase
    end
  end

  // firmware flags; plain storage, no effect on mode
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || (mode == PMR_SHUTDOWN && shutdown_exit)) begin
      fw_flags <= PMR_RST_POWER_CONTROL[PMR_POS_FW_FLAGS +: PMR_NUM_FW_FLAGS];
    end else if (sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL)) begin
      fw_flags <= sfr_wdata_in[PMR_POS_FW_FLAGS +: PMR_NUM_FW_FLAGS];
    end
  end

  // wake flags: set wins over a firmware clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || (mode == PMR_SHUTDOWN && shutdown_exit)) begin
      wake <= pmr_wake_t'(PMR_RST_WAKE_FLAGS[PMR_NUM_WAKE-1:0]);
    end else if (mode != PMR_SHUTDOWN) begin
      if (sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_WAKE_FLAGS)) begin
        wake <= pmr_wake_t'((wake & sfr_wdata_in[PMR_NUM_WAKE-1:0]) | wake_evt);
      end else begin
        wake <= pmr_wake_t'(wake | wake_evt);
      end
    end
  end

  // comparator edge history
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cmp_prev <= 1'b0;
    end else begin
      cmp_prev <= comparator_zero_in;
    end
  end

  // regulator configuration
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || (mode == PMR_SHUTDOWN && shutdown_exit)) begin
      shutdown_cfg <= PMR_RST_CORE_REG[PMR_BIT_SHUTDOWN_CFG];
      five_volt.off <= PMR_RST_FIVE_VOLT_REG[PMR_BIT_REG_OFF];
      five_volt.bias_off <= PMR_RST_FIVE_VOLT_REG[PMR_BIT_BIAS_OFF];
      five_volt.low_bias <= PMR_RST_FIVE_VOLT_REG[PMR_BIT_LOW_BIAS];
    end else begin
      if (sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_CORE_REG)) begin
        shutdown_cfg <= sfr_wdata_in[PMR_BIT_SHUTDOWN_CFG];
      end
      if (sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_FIVE_VOLT_REG)) begin
        five_volt.off <= sfr_wdata_in[PMR_BIT_REG_OFF];
        five_volt.bias_off <= sfr_wdata_in[PMR_BIT_BIAS_OFF];
        five_volt.low_bias <= sfr_wdata_in[PMR_BIT_LOW_BIAS];
      end
    end
  end

  // power-on report, set on shutdown exit and held until next reset
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      por_flag <= 1'b0;
    end else if (mode == PMR_SHUTDOWN && shutdown_exit) begin
      por_flag <= 1'b1;
    end else if (power_on_reset_in) begin
      por_flag <= 1'b1;
    end
  end

  // read mux; request bits always read 0
  always_comb begin
    next_rdata = 8'h00;
    if (hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL)) begin
      next_rdata[PMR_POS_FW_FLAGS +: PMR_NUM_FW_FLAGS] = fw_flags;
    end else if (hit(sfr_addr_in, PMR_ADDR_WAKE_FLAGS)) begin
      next_rdata[PMR_NUM_WAKE-1:0] = wake;
    end else if (hit(sfr_addr_in, PMR_ADDR_FIVE_VOLT_REG)) begin
      next_rdata[PMR_BIT_REG_OFF] = five_volt.off;
      next_rdata[PMR_BIT_BIAS_OFF] = five_volt.bias_off;
      next_rdata[PMR_BIT_LOW_BIAS] = five_volt.low_bias;
    end else if (hit(sfr_addr_in, PMR_ADDR_CORE_REG)) begin
      next_rdata[PMR_BIT_SHUTDOWN_CFG] = shutdown_cfg;
    end
  end

  // read latch is lost in shutdown like every other register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || (mode == PMR_SHUTDOWN && shutdown_exit)) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= next_rdata;
    end
  end

  assign mode_out = mode;
  assign core_halt_out = (mode != PMR_NORMAL);
  assign sysclk_gate_out = (mode == PMR_SUSPEND) || (mode == PMR_SNOOZE) || (mode == PMR_STOP)
                           || (mode == PMR_SHUTDOWN);
  assign fast_osc_halt_out = sysclk_gate_out;
  assign core_ldo_standby_out = (mode == PMR_SNOOZE);
  assign core_ldo_off_out = (mode == PMR_SHUTDOWN);
  assign pin_hold_out = (mode == PMR_SHUTDOWN) || (mode == PMR_STOP);
  assign debug_attach_ok_out = debug_attach_req_in && (mode != PMR_SHUTDOWN);
  // internal resets are masked in shutdown
  assign device_reset_out = (mode == PMR_SHUTDOWN) ? shutdown_exit : stop_exit;
  assign por_reported_out = por_flag;
  assign five_volt_low_bias_out = five_volt.low_bias & ~five_volt.bias_off;
  assign five_volt_bias_off_out = five_volt.bias_off;
  assign five_volt_off_out = five_volt.off & five_volt.bias_off;

  a_shutdown_entry: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_NORMAL && sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL)
     && sfr_wdata_in[PMR_BIT_STOP] && shutdown_cfg) |=> mode == PMR_SHUTDOWN)
    else $error("stop with shutdown config did not enter shutdown");
  a_shutdown_ignores: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_SHUTDOWN && !shutdown_exit) |=> mode == PMR_SHUTDOWN && !$past(device_reset_out))
    else $error("shutdown left without pin or power reset");
  a_shutdown_clears: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_SHUTDOWN && shutdown_exit) |=> (wake == '0 && fw_flags == '0 && !shutdown_cfg))
    else $error("registers survived shutdown");
  a_por_report: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_SHUTDOWN && shutdown_exit) |=> por_reported_out)
    else $error("shutdown exit not reported as power-on");
  a_no_debug: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode == PMR_SHUTDOWN |-> !debug_attach_ok_out)
    else $error("debug attached in shutdown");
  a_stop_exit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_STOP && internal_reset_in) |=> mode == PMR_NORMAL)
    else $error("stop not left on internal reset");
  a_req_read_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $past(sfr_rd_in) |-> sfr_rdata_out[1:0] == 2'b00 || $past(sfr_addr_in) != PMR_ADDR_POWER_CONTROL)
    else $error("request bit read back as 1");
  a_wake_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (wake.timer_four && !(sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_WAKE_FLAGS))
     && mode != PMR_SHUTDOWN) |=> wake.timer_four)
    else $error("wake flag dropped without firmware clear");
  a_cmp_edge: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ($fell(comparator_zero_in) && mode != PMR_SHUTDOWN) |=> wake.comparator_zero)
    else $error("comparator falling edge missed");
  a_bias_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    five_volt_bias_off_out |-> !five_volt_low_bias_out)
    else $error("low bias active with bias off");
  a_reg_off_bias: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    five_volt_off_out |-> five_volt_bias_off_out)
    else $error("regulator off without bias off");
  a_suspend_entry: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_NORMAL && sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL_EXT)
     && sfr_wdata_in[PMR_BIT_SUSPEND] && !sfr_wdata_in[PMR_BIT_SNOOZE]
     && fast_internal_osc_a_sel_in) |=> mode == PMR_SUSPEND)
    else $error("suspend request did not enter suspend");
  a_osc_refused: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_NORMAL && sfr_wr_in && hit(sfr_addr_in, PMR_ADDR_POWER_CONTROL_EXT)
     && !fast_internal_osc_a_sel_in) |=> mode == PMR_NORMAL)
    else $error("low power request taken off the slow clock");
  a_snooze_outputs: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode == PMR_SNOOZE |-> (core_ldo_standby_out && fast_osc_halt_out && sysclk_gate_out))
    else $error("snooze outputs wrong");
  a_wake_exit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ((mode == PMR_SUSPEND || mode == PMR_SNOOZE) && any_wake) |=> mode == PMR_NORMAL)
    else $error("wake event did not end suspend or snooze");
  a_idle_exit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_IDLE && irq_pending_in) |=> mode == PMR_NORMAL)
    else $error("interrupt did not end idle");
  a_shutdown_outputs: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode == PMR_SHUTDOWN |-> (core_halt_out && core_ldo_off_out && pin_hold_out))
    else $error("shutdown outputs wrong");
  a_reset_masked: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode == PMR_SHUTDOWN && !shutdown_exit) |-> !device_reset_out)
    else $error("internal reset passed in shutdown");
  c_shutdown: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode == PMR_SHUTDOWN ##1 mode == PMR_NORMAL);
  c_snooze: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode == PMR_SNOOZE ##1 mode == PMR_NORMAL);
  c_idle: cover property (@(posedge mclk_in) disable iff (!rst_n_in) mode == PMR_IDLE);
  c_suspend: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode == PMR_SUSPEND ##1 mode == PMR_NORMAL);
  c_stop: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode == PMR_STOP ##1 mode == PMR_NORMAL);
endmodule

/* File: verification/pmr_power_ctrl_bench.sv */
// self-checking bench for the power mode and regulator control block
`timescale 1ns/100ps
module pmr_power_ctrl_bench;
  import pmr_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pin_n = 1'b1, por = 1'b0, irst = 1'b0, irq = 1'b0, osc = 1'b0, dbg = 1'b0;
  // comparator line idles high, ev[0] pulls it low for a falling edge
  logic [5:0] ev = 6'h00;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0;
  logic [7:0] rdata;
  logic halt, gate, osc_halt, ldo_off, ldo_stby, hold, dbg_ok, dev_rst, por_rep, lb, bo, off;
  pmr_mode_t mode;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] regs [5] = '{PMR_ADDR_POWER_CONTROL, PMR_ADDR_WAKE_FLAGS, PMR_ADDR_FIVE_VOLT_REG,
    PMR_ADDR_CORE_REG, PMR_ADDR_POWER_CONTROL_EXT};
  logic [7:0] rv [5] = '{8'h02, 8'h06, 8'h04, 8'h84, 8'h80};
  logic [2:0] ro [5] = '{3'h4, 3'h2, 3'h2, 3'h3, 3'h0};
  logic [7:0] mask;

  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  pmr_power_ctrl u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .external_reset_pin_n_in(pin_n),
    .power_on_reset_in(por), .internal_reset_in(irst), .irq_pending_in(irq), .fast_internal_osc_a_sel_in(osc),
    .logic_unit_event_in(ev[5]), .usb_resume_event_in(ev[4]), .serial_slave_byte_in(ev[3]),
    .timer_four_ovf_in(ev[2]), .pin_match_event_in(ev[1]), .comparator_zero_in(~ev[0]),
    .debug_attach_req_in(dbg), .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_rdata_out(rdata), .core_halt_out(halt), .sysclk_gate_out(gate), .fast_osc_halt_out(osc_halt),
    .core_ldo_off_out(ldo_off), .core_ldo_standby_out(ldo_stby), .pin_hold_out(hold),
    .debug_attach_ok_out(dbg_ok), .device_reset_out(dev_rst), .por_reported_out(por_rep),
    .five_volt_low_bias_out(lb), .five_volt_bias_off_out(bo), .five_volt_off_out(off), .mode_out(mode));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge mclk_in);
    #1;
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_mode(input pmr_mode_t exp);
    cmp_count++;
    if (mode !== exp) begin
      error_cnt++;
      $display("mismatch mode expected %h seen %h", exp, mode);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    step();
    addr = a;
    wdata = d;
    wr = 1'b1;
    step();
    wr = 1'b0;
  endtask

  // rdata is registered, so look one full cycle after the read edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    step();
    addr = a;
    rd = 1'b1;
    step();
    rd = 1'b0;
    step();
    chk_byte("register read", exp, rdata);
  endtask

  task automatic pulse(input int i);
    step();
    ev[i] = 1'b1;
    step();
    ev = 6'h00;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_in);
    error_cnt++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    repeat (12) @(posedge mclk_in);
    #1;
    rst_n_in = 1'b1;
    for (int i = 0; i < 5; i++) rd_chk(regs[i], 8'h00);
    rd_chk(8'h00, 8'h00);
    chk_byte("five volt outputs", 8'h00, {5'h00, lb, bo, off});
    $display("test reset values done");
    wr_reg(PMR_ADDR_POWER_CONTROL, 8'hFC);
    rd_chk(PMR_ADDR_POWER_CONTROL, 8'hFC);
    chk_mode(PMR_NORMAL);
    wr_reg(PMR_ADDR_POWER_CONTROL, 8'hFD);
    chk_mode(PMR_IDLE);
    chk_bit("core halt", 1'b1, halt);
    rd_chk(PMR_ADDR_POWER_CONTROL, 8'hFC);
    irq = 1'b1;
    step();
    irq = 1'b0;
    chk_mode(PMR_NORMAL);
    wr_reg(PMR_ADDR_POWER_CONTROL, 8'h02);
    chk_mode(PMR_STOP);
    chk_byte("stop outputs", 8'h0D, {4'h0, halt, gate, ldo_off, hold});
    irst = 1'b1;
    #1;
    chk_bit("device reset", 1'b1, dev_rst);
    step();
    irst = 1'b0;
    chk_mode(PMR_NORMAL);
    $display("test power control done");
    for (int i = 0; i < 5; i++) begin
      wr_reg(PMR_ADDR_FIVE_VOLT_REG, rv[i]);
      rd_chk(PMR_ADDR_FIVE_VOLT_REG, rv[i]);
      chk_byte("five volt outputs", {5'h00, ro[i]}, {5'h00, lb, bo, off});
    end
    wr_reg(PMR_ADDR_FIVE_VOLT_REG, 8'h00);
    $display("test regulator done");
    mask = 8'h00;
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      mask[i] = 1'b1;
      rd_chk(PMR_ADDR_WAKE_FLAGS, mask);
    end
    wr_reg(PMR_ADDR_WAKE_FLAGS, 8'h3E);
    rd_chk(PMR_ADDR_WAKE_FLAGS, 8'h3E);
    wr_reg(PMR_ADDR_WAKE_FLAGS, 8'h00);
    rd_chk(PMR_ADDR_WAKE_FLAGS, 8'h00);
    // a clear and a usb resume event on the same edge: the event must win
    step();
    addr = PMR_ADDR_WAKE_FLAGS;
    wdata = 8'h00;
    wr = 1'b1;
    ev[4] = 1'b1;
    step();
    wr = 1'b0;
    ev = 6'h00;
    rd_chk(PMR_ADDR_WAKE_FLAGS, 8'h10);
    $display("test wake flags done");
    wr_reg(PMR_ADDR_POWER_CONTROL_EXT, 8'h40);
    chk_mode(PMR_NORMAL);
    osc = 1'b1;
    wr_reg(PMR_ADDR_POWER_CONTROL_EXT, 8'h40);
    chk_mode(PMR_SUSPEND);
    chk_byte("suspend outputs", 8'h06, {5'h00, gate, osc_halt, ldo_stby});
    pulse(2);
    chk_mode(PMR_NORMAL);
    wr_reg(PMR_ADDR_POWER_CONTROL_EXT, 8'h80);
    chk_mode(PMR_SNOOZE);
    chk_byte("snooze outputs", 8'h07, {5'h00, gate, osc_halt, ldo_stby});
    pulse(3);
    chk_mode(PMR_NORMAL);
    osc = 1'b0;
    wr_reg(PMR_ADDR_WAKE_FLAGS, 8'h00);
    $display("test suspend and snooze done");
    // pass 0 leaves through the reset pin, pass 1 through a power cycle
    for (int j = 0; j < 2; j++) begin
      // mid-run reset, so each pass starts with the report cleared
      rst_n_in = 1'b0;
      step();
      step();
      rst_n_in = 1'b1;
      chk_bit("power-on report", 1'b0, por_rep);
      chk_mode(PMR_NORMAL);
      wr_reg(PMR_ADDR_POWER_CONTROL, 8'h08);
      wr_reg(PMR_ADDR_FIVE_VOLT_REG, 8'h02);
      wr_reg(PMR_ADDR_CORE_REG, 8'h08);
      rd_chk(PMR_ADDR_CORE_REG, 8'h08);
      wr_reg(PMR_ADDR_POWER_CONTROL, 8'h0A);
      chk_mode(PMR_SHUTDOWN);
      chk_byte("shutdown outputs", 8'h07, {5'h00, halt, ldo_off, hold});
      dbg = 1'b1;
      irst = 1'b1;
      irq = 1'b1;
      ev = 6'h3F;
      #1;
      chk_bit("debug attach", 1'b0, dbg_ok);
      chk_bit("device reset", 1'b0, dev_rst);
      step();
      irst = 1'b0;
      irq = 1'b0;
      ev = 6'h00;
      step();
      chk_mode(PMR_SHUTDOWN);
      if (j == 0) begin
        pin_n = 1'b0;
      end else begin
        por = 1'b1;
      end
      #1;
      chk_bit("device reset", 1'b1, dev_rst);
      step();
      pin_n = 1'b1;
      por = 1'b0;
      chk_mode(PMR_NORMAL);
      chk_bit("power-on report", 1'b1, por_rep);
      chk_bit("debug attach", 1'b1, dbg_ok);
      dbg = 1'b0;
      for (int i = 0; i < 5; i++) rd_chk(regs[i], 8'h00);
    end
    $display("test shutdown done");
    complete_run();
  end
endmodule
